// [src/weld_seq_pkg.sv]
package weld_seq_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_SETUP   = 8'h04;
   localparam logic [7:0] OFS_TIMES0  = 8'h08;
   localparam logic [7:0] OFS_TIMES1  = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_PF_READ = 8'h14;
   localparam logic [7:0] OFS_CURRENT = 8'h18;
   // Field positions of SETUP
   localparam int SETUP_INIT_POS  = 0;
   localparam int SETUP_PHDLY_POS = 8;
   localparam int SETUP_PF_POS    = 16;
   localparam int SETUP_PO_POS    = 24;
   // Field positions of CTRL
   localparam int CTRL_TR_POS     = 0;
   localparam int CTRL_CC_POS     = 8;
   localparam int CTRL_CMODE_POS  = 16;
   localparam int CTRL_REPEAT_POS = 24;
   // Reset values
   localparam logic [31:0] RST_SETUP  = 32'h0000_0100;
   localparam logic [31:0] RST_CTRL   = 32'h0000_000A;
   localparam logic [31:0] RST_TIMES  = 32'h0000_0000;
   // Codes
   localparam logic [7:0] INIT_NONBEAT   = 8'h00;
   localparam logic [7:0] INIT_WELD_STOP = 8'h04;
   localparam logic [7:0] INIT_CMODE5    = 8'h05;
   localparam logic [7:0] INIT_STEPPER   = 8'h06;
   localparam logic [7:0] PHDLY_OFF      = 8'h00;
   localparam logic [7:0] PHDLY_ON       = 8'h01;
   localparam logic [7:0] PF_AUTO        = 8'h00;
   localparam logic [7:0] PO_VALVE3_OFF  = 8'h07;
   localparam logic [7:0] TR_MIN         = 8'd10;
   localparam logic [7:0] TR_MAX         = 8'd255;
   localparam logic [7:0] CMODE_05       = 8'h05;
   // Mains line cycles are 60 per second
   localparam int LINE_HZ        = 60;
   localparam int PCLK_HZ        = 40_000_000;
   localparam int LINE_CYC_CLKS  = PCLK_HZ / LINE_HZ;

   typedef enum logic [5:0] {
      ST_IDLE    = 6'b000001,
      ST_PRESQZ  = 6'b000010,
      ST_SQUEEZE = 6'b000100,
      ST_WELD    = 6'b001000,
      ST_HOLD    = 6'b010000,
      ST_OFF     = 6'b100000
   } phase_e;

   typedef struct packed {
      logic [31:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic        valve_on;
      logic        valve3;
      logic        retract;
      logic        weld_fire;
      logic        phase_delay_en;
      logic        display_dim;
      logic        stepper_reset;
      logic        compensate;
      logic        monitor;
      logic [2:0]  range_sel;
   } weld_out_s;
endpackage

// [src/weld_sequence_option_logic.sv]
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module weld_sequence_option_logic (
   // Clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // APB slave
   input  wire weld_seq_pkg::apb_req_s     apb_req,
   output weld_seq_pkg::apb_rsp_s          apb_rsp,
   // Pins
   input  wire logic                       pilot_switch_input,
   input  wire logic                       weld_inhibit_input,
   input  wire logic                       estop_terminal,
   // Measurements
   input  wire logic [15:0]                primary_current,
   input  wire logic [7:0]                 pf_measured,
   // Outputs
   output weld_seq_pkg::weld_out_s         weld_out
);
   import weld_seq_pkg::*;

   typedef struct packed {
      apb_rsp_s    rsp;
      weld_out_s   out;
      logic [31:0] setup;
      logic [31:0] ctrl;
      logic [31:0] times0;
      logic [31:0] times1;
      logic [7:0]  pf_last;
      logic [23:0] sec_current;
      phase_e      phase;
      logic [7:0]  cnt;
      logic [7:0]  blk_cnt;
      logic        blk_run;
      logic        first_sqz;
      logic [19:0] tick;
      logic [1:0]  pilot_sy;
      logic [1:0]  inh_sy;
      logic [1:0]  es_sy;
      logic        es_prev;
   } state_s;

   state_s cur;
   state_s next_cur;

   // Codes 10..19 and 30..33 preset range index
   function automatic logic [2:0] range_of(input logic [7:0] code);
      range_of = 3'h0;
      if (code == 8'h10 || code == 8'h11) range_of = 3'h1;
      else if (code == 8'h12 || code == 8'h13) range_of = 3'h2;
      else if (code == 8'h14 || code == 8'h15) range_of = 3'h3;
      else if (code == 8'h16 || code == 8'h17) range_of = 3'h4;
      else if (code == 8'h18 || code == 8'h19) range_of = 3'h5;
      else if (code == 8'h30 || code == 8'h31) range_of = 3'h6;
      else if (code == 8'h32 || code == 8'h33) range_of = 3'h7;
   endfunction

   logic [7:0] init_mode;
   logic [7:0] pf_set;
   logic [7:0] phdly_set;
   logic [7:0] po_code;
   logic [7:0] cmode;
   logic [7:0] t_presqz;
   logic [7:0] t_sqz;
   logic [7:0] t_weld;
   logic [7:0] t_hold;
   logic [7:0] t_off;
   logic [7:0] t_blk;
   logic       line_tick;
   logic       pilot;
   logic       inhibit_open;
   logic       es_closed;
   logic       es_open_edge;
   logic       es_close_edge;
   logic       apb_access;
   logic       overlap_ok;
   logic [7:0] tr_wr;

   // Field views of the configuration registers
   assign init_mode    = cur.setup[SETUP_INIT_POS +: 8];
   assign pf_set       = cur.setup[SETUP_PF_POS +: 8];
   assign phdly_set    = cur.setup[SETUP_PHDLY_POS +: 8];
   assign po_code      = cur.setup[SETUP_PO_POS +: 8];
   assign cmode        = cur.ctrl[CTRL_CMODE_POS +: 8];
   assign t_presqz     = cur.times0[7:0];
   assign t_sqz        = cur.times0[15:8];
   assign t_weld       = cur.times0[23:16];
   assign t_hold       = cur.times0[31:24];
   assign t_off        = cur.times1[7:0];
   assign t_blk        = cur.times1[15:8];
   // Line ticks come from a fixed divider of pclk; mains frequency drift
   // is not tracked, so long intervals may slip by a fraction of a cycle
   assign line_tick    = (cur.tick == 20'(LINE_CYC_CLKS - 1));
   assign pilot        = cur.pilot_sy[1];
   assign inhibit_open = cur.inh_sy[1];
   assign es_closed    = cur.es_sy[1];
   assign es_open_edge = cur.es_prev & ~es_closed;
   assign es_close_edge = ~cur.es_prev & es_closed;
   assign apb_access   = apb_req.psel & apb_req.penable;
   // Blocking overlap only for sequences ending in cycle modes 00, 01, 03
   assign overlap_ok   = (cmode == 8'h00) || (cmode == 8'h01) || (cmode == 8'h03);
   // Clamp a written turns ratio into its legal span
   assign tr_wr = (apb_req.pwdata[7:0] < TR_MIN) ? TR_MIN : apb_req.pwdata[7:0];

   // Next-state logic for the whole block
   always_comb begin
      next_cur = cur;
      next_cur.pilot_sy = {cur.pilot_sy[0], pilot_switch_input};
      next_cur.inh_sy   = {cur.inh_sy[0], weld_inhibit_input};
      next_cur.es_sy    = {cur.es_sy[0], estop_terminal};
      next_cur.es_prev  = es_closed;
      next_cur.tick     = line_tick ? 20'h0 : cur.tick + 20'h1;
      next_cur.rsp.pready  = 1'b0;
      next_cur.rsp.pslverr = 1'b0;
      next_cur.out.stepper_reset = 1'b0;

      // APB: one wait state, answer in the cycle after the access begins
      if (apb_access && !cur.rsp.pready) begin
         next_cur.rsp.pready = 1'b1;
         next_cur.rsp.prdata = 32'h0;
         if (apb_req.pwrite) begin
            if (apb_req.paddr[7:0] == OFS_CTRL) begin
               next_cur.ctrl = {apb_req.pwdata[31:8], tr_wr};
               // Cycle mode 05 is programmable only with init mode 05
               if (apb_req.pwdata[CTRL_CMODE_POS +: 8] == CMODE_05 && init_mode != INIT_CMODE5)
                  next_cur.ctrl[CTRL_CMODE_POS +: 8] = cur.ctrl[CTRL_CMODE_POS +: 8];
            end else if (apb_req.paddr[7:0] == OFS_SETUP) begin
               next_cur.setup = apb_req.pwdata;
               if (apb_req.pwdata[SETUP_PHDLY_POS +: 8] > PHDLY_ON)
                  next_cur.setup[SETUP_PHDLY_POS +: 8] = cur.setup[SETUP_PHDLY_POS +: 8];
            end else if (apb_req.paddr[7:0] == OFS_TIMES0) begin
               next_cur.times0 = apb_req.pwdata;
            end else if (apb_req.paddr[7:0] == OFS_TIMES1) begin
               next_cur.times1 = {16'h0, apb_req.pwdata[15:0]};
            end else if (apb_req.paddr[7:0] > OFS_CURRENT) begin
               next_cur.rsp.pslverr = 1'b1;
            end
         end else begin
            if (apb_req.paddr[7:0] == OFS_CTRL) next_cur.rsp.prdata = cur.ctrl;
            else if (apb_req.paddr[7:0] == OFS_SETUP) next_cur.rsp.prdata = cur.setup;
            else if (apb_req.paddr[7:0] == OFS_TIMES0) next_cur.rsp.prdata = cur.times0;
            else if (apb_req.paddr[7:0] == OFS_TIMES1) next_cur.rsp.prdata = cur.times1;
            else if (apb_req.paddr[7:0] == OFS_STATUS) next_cur.rsp.prdata = {26'h0, cur.phase};
            else if (apb_req.paddr[7:0] == OFS_PF_READ) next_cur.rsp.prdata = {24'h0, cur.pf_last};
            else if (apb_req.paddr[7:0] == OFS_CURRENT) next_cur.rsp.prdata = {8'h0, cur.sec_current};
            else next_cur.rsp.pslverr = 1'b1;
         end
      end

      // Secondary current from primary sensing uses the turns ratio
      if (range_of(cur.ctrl[CTRL_CC_POS +: 8]) inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5})
         next_cur.sec_current = {8'h0, primary_current} * {16'h0, cur.ctrl[CTRL_TR_POS +: 8]};
      else
         next_cur.sec_current = {8'h0, primary_current};

      // Current mode decode; even codes with a range correct, odd codes only measure
      next_cur.out.range_sel  = range_of(cur.ctrl[CTRL_CC_POS +: 8]);
      next_cur.out.monitor    = (next_cur.out.range_sel != 3'h0);
      next_cur.out.compensate = next_cur.out.monitor & ~cur.ctrl[CTRL_CC_POS];
      // Automatic mode ignores the phase-delay setting and keeps it on
      next_cur.out.phase_delay_en = (pf_set == PF_AUTO) ? 1'b1 :
                                    (cur.setup[SETUP_PHDLY_POS +: 8] == PHDLY_ON);

      // Estop closure in mode 06 is a stepper reset command
      if (init_mode == INIT_STEPPER && es_close_edge)
         next_cur.out.stepper_reset = 1'b1;
      // Sequence engine, counted in line cycles
      case (cur.phase)
         ST_IDLE: begin
            if (pilot && es_closed) begin
               next_cur.out.valve3 = 1'b0;
               next_cur.first_sqz  = 1'b0;
               next_cur.cnt        = t_presqz;
               next_cur.phase      = (t_presqz != 8'h0) ? ST_PRESQZ : ST_SQUEEZE;
               if (t_presqz == 8'h0) next_cur.cnt = t_sqz;
            end
         end
         ST_PRESQZ: begin
            if (line_tick) next_cur.cnt = cur.cnt - 8'h1;
            if (line_tick && cur.cnt == 8'h1) begin
               next_cur.phase = ST_SQUEEZE;
               next_cur.cnt   = t_sqz;
            end
         end
         ST_SQUEEZE: begin
            if (line_tick) next_cur.cnt = cur.cnt - 8'h1;
            if (cur.cnt == 8'h0 || (line_tick && cur.cnt == 8'h1)) begin
               next_cur.phase = ST_WELD;
               next_cur.cnt   = t_weld;
            end
         end
         ST_WELD: begin
            if (line_tick) next_cur.cnt = cur.cnt - 8'h1;
            // Mode 04 cuts WELD short on an open inhibit input
            if ((init_mode == INIT_WELD_STOP && inhibit_open) || cur.cnt == 8'h0 ||
                (line_tick && cur.cnt == 8'h1)) begin
               next_cur.phase   = ST_HOLD;
               next_cur.cnt     = t_hold;
               next_cur.pf_last = pf_measured;
            end
         end
         ST_HOLD: begin
            if (line_tick) next_cur.cnt = cur.cnt - 8'h1;
            if (cur.cnt == 8'h0 || (line_tick && cur.cnt == 8'h1)) begin
               next_cur.phase   = ST_OFF;
               next_cur.blk_run = overlap_ok && (t_blk != 8'h0);
               next_cur.blk_cnt = t_blk;
               next_cur.out.retract = overlap_ok && (t_blk != 8'h0);
               // Overlap: OFF no longer than blocking is skipped, else shortened
               if (overlap_ok && t_off <= t_blk) next_cur.cnt = 8'h0;
               else if (overlap_ok) next_cur.cnt = t_off - t_blk;
               else next_cur.cnt = t_off;
            end
         end
         ST_OFF: begin
            if (cur.blk_run) begin
               if (line_tick) next_cur.blk_cnt = cur.blk_cnt - 8'h1;
               if (line_tick && cur.blk_cnt == 8'h1) begin
                  next_cur.blk_run = 1'b0;
                  next_cur.out.retract = 1'b0;
                  if (po_code == PO_VALVE3_OFF) next_cur.out.valve3 = 1'b1;
               end
            end else begin
               if (line_tick && cur.cnt != 8'h0) next_cur.cnt = cur.cnt - 8'h1;
               if (cur.cnt == 8'h0 || (line_tick && cur.cnt == 8'h1)) begin
                  // Repeat restarts at SQUEEZE, never at pre-squeeze
                  if (cur.ctrl[CTRL_REPEAT_POS] && pilot) begin
                     next_cur.phase = ST_SQUEEZE;
                     next_cur.cnt   = t_sqz;
                  end else begin
                     next_cur.phase = ST_IDLE;
                  end
               end
            end
         end
         default: next_cur.phase = ST_IDLE;
      endcase

      // Estop opening drops the retraction output; placed after the case so a
      // HOLD-to-OFF step in the same clock cannot switch it back on
      if (es_open_edge)
         next_cur.out.retract = 1'b0;

      // Only an open estop aborts a running sequence, in any init mode but 06
      if (!es_closed && init_mode != INIT_STEPPER) begin
         next_cur.phase   = ST_IDLE;
         next_cur.blk_run = 1'b0;
      end

      next_cur.out.valve_on    = (next_cur.phase != ST_IDLE);
      next_cur.out.weld_fire   = (next_cur.phase == ST_WELD);
      next_cur.out.display_dim = (next_cur.phase == ST_PRESQZ);
   end

   // Whole state registered at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur        <= '0;
         cur.setup  <= RST_SETUP;
         cur.ctrl   <= RST_CTRL;
         cur.times0 <= RST_TIMES;
         cur.times1 <= RST_TIMES;
         cur.phase  <= ST_IDLE;
         cur.out.phase_delay_en <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign apb_rsp  = cur.rsp;
   assign weld_out = cur.out;

   // Inhibit opening in WELD under mode 04 leaves WELD within one clock
   AST_WELD_CUT: assert property (@(posedge pclk) disable iff (!presetn)
      (cur.phase == ST_WELD && init_mode == INIT_WELD_STOP && inhibit_open && es_closed)
      |=> cur.phase == ST_HOLD) else $error("weld not cut short");

   // A closure in mode 06 gives a stepper reset pulse of one clock
   AST_STEPPER: assert property (@(posedge pclk) disable iff (!presetn)
      (init_mode == INIT_STEPPER && es_close_edge) |=> weld_out.stepper_reset)
      else $error("stepper reset missing");

   AST_STEP_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      weld_out.stepper_reset |=> !weld_out.stepper_reset) else $error("stepper reset too long");

   // Automatic factor keeps the phase delay on; manual mode follows the setting
   AST_PHDLY_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 ($past(pf_set) == PF_AUTO) |-> weld_out.phase_delay_en)
      else $error("phase delay off in auto mode");

   AST_PHDLY_MANUAL: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 ($past(pf_set) != PF_AUTO) |-> weld_out.phase_delay_en == ($past(phdly_set) == PHDLY_ON))
      else $error("phase delay ignores manual setting");

   // The factor read back is the one seen as WELD ends
   AST_PF_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
      (cur.phase == ST_WELD && next_cur.phase == ST_HOLD) |=> cur.pf_last == $past(pf_measured))
      else $error("power factor not captured");

   // Output flags track the phase register one for one
   AST_VALVE_ON: assert property (@(posedge pclk) disable iff (!presetn)
      weld_out.valve_on == (cur.phase != ST_IDLE)) else $error("valves not energized in sequence");

   AST_DIM: assert property (@(posedge pclk) disable iff (!presetn)
      (cur.phase == ST_SQUEEZE) |-> !weld_out.display_dim)
      else $error("display dim in squeeze");

   AST_DIM_PRESQZ: assert property (@(posedge pclk) disable iff (!presetn)
      weld_out.display_dim == (cur.phase == ST_PRESQZ)) else $error("display not dim in presqueeze");

   AST_FIRE: assert property (@(posedge pclk) disable iff (!presetn)
      weld_out.weld_fire == (cur.phase == ST_WELD)) else $error("firing outside weld");

   // Estop opening drops retraction and aborts every mode but the stepper one
   AST_RETRACT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      es_open_edge |=> !weld_out.retract) else $error("retract not dropped");

   AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
      (!es_closed && init_mode != INIT_STEPPER) |=> cur.phase == ST_IDLE)
      else $error("sequence not aborted");

   // Blocking overlap either skips OFF or trims it
   AST_OFF_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
      (cur.phase == ST_HOLD && next_cur.phase == ST_OFF && overlap_ok && t_off <= t_blk)
      |=> cur.cnt == 8'h00) else $error("short OFF not skipped");

   AST_OFF_TRIM: assert property (@(posedge pclk) disable iff (!presetn)
      (cur.phase == ST_HOLD && next_cur.phase == ST_OFF && overlap_ok && t_off > t_blk)
      |=> cur.cnt == $past(t_off) - $past(t_blk)) else $error("OFF not trimmed by blocking");

   // Valve 3 drops at each new initiation
   AST_VALVE3_INIT: assert property (@(posedge pclk) disable iff (!presetn)
      (cur.phase == ST_IDLE && next_cur.phase != ST_IDLE) |=> !weld_out.valve3)
      else $error("valve 3 held into new sequence");

   AST_TR_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      cur.ctrl[CTRL_TR_POS +: 8] >= TR_MIN) else $error("turns ratio below range");

   AST_REPEAT: assert property (@(posedge pclk) disable iff (!presetn)
      (cur.phase == ST_OFF) |=> cur.phase != ST_PRESQZ) else $error("presqueeze on repeat");

   // Current mode decode: code 00 leaves sensing and correction off
   AST_CC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (cur.ctrl[CTRL_CC_POS +: 8] == 8'h00) |=> (weld_out.range_sel == 3'h0 && !weld_out.monitor))
      else $error("current mode active at code 00");

   AST_COMP_ODD: assert property (@(posedge pclk) disable iff (!presetn)
      weld_out.compensate |-> weld_out.monitor) else $error("compensate without measure");
endmodule

// [bench/weld_far_side.sv]
`timescale 1ns/10ps
// Machine side of the controller: operator switches, estop button and sensors
module weld_far_side (
   // Clock
   input  wire logic         pclk,
   // Switch levels, high means closed except the inhibit input
   output logic              pilot_switch_input,
   output logic              weld_inhibit_input,
   output logic              estop_terminal,
   // Sensor readings
   output logic [15:0]       primary_current,
   output logic [7:0]        pf_measured
);
   // Idle machine: pilot open, welding permitted, estop loop closed
   initial begin
      pilot_switch_input = 1'b0;
      weld_inhibit_input = 1'b0;
      estop_terminal     = 1'b1;
      primary_current    = 16'h0000;
      pf_measured        = 8'h55;
   end

   // Operator holds or releases the pilot switch
   task automatic set_pilot(input logic lvl);
      @(posedge pclk);
      pilot_switch_input <= lvl;
   endtask

   // Weld/no-weld contact; high opens it, which cuts WELD short in init mode 04
   task automatic set_inhibit(input logic lvl);
      @(posedge pclk);
      weld_inhibit_input <= lvl;
   endtask

   // Momentary button on the estop pair; a short blip is shorter than one line cycle
   task automatic estop_pulse(input logic lvl, input int n);
      @(posedge pclk);
      estop_terminal <= lvl;
      repeat (n) @(posedge pclk);
      estop_terminal <= ~lvl;
   endtask

   // Current transformer reading changes only between transfers
   task automatic set_current(input logic [15:0] cur);
      @(posedge pclk);
      primary_current <= cur;
   endtask
endmodule

// [bench/weld_sequence_option_logic_tb.sv]
`timescale 1ns/10ps
module weld_sequence_option_logic_tb;
   import weld_seq_pkg::*;
   logic        pclk, presetn, pilot, inhibit, estop, err;
   logic        step_seen = 1'b0;
   logic [15:0] cur;
   logic [7:0]  pf;
   logic [31:0] rd;
   apb_req_s    req;
   apb_rsp_s    rsp;
   weld_out_s   wo;
   int          error_cnt, samples_checked, cyc;
   // Constant-current codes and the range each one selects
   logic [7:0]  cc_code [15] = '{8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
                                 8'h17, 8'h18, 8'h19, 8'h30, 8'h31, 8'h32, 8'h33};
   logic [2:0]  cc_rng  [15] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4,
                                 3'h5, 3'h5, 3'h6, 3'h6, 3'h7, 3'h7};

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   weld_sequence_option_logic dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .pilot_switch_input(pilot), .weld_inhibit_input(inhibit), .estop_terminal(estop),
      .primary_current(cur), .pf_measured(pf), .weld_out(wo));

   weld_far_side far (.pclk(pclk), .pilot_switch_input(pilot), .weld_inhibit_input(inhibit),
      .estop_terminal(estop), .primary_current(cur), .pf_measured(pf));

   task automatic end_of_test;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request stands until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{paddr: {24'h0, a}, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // Wait for the slave; only the bench's cycle ceiling ends a hang
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   // Hang guard well above the few hundred cycles the tests need
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (wo.stepper_reset === 1'b1) step_seen <= 1'b1;
      if (cyc == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end

   initial begin
      presetn = 1'b0;
      req = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      // Reset contents and the unmapped hole above the map
      xfer(1'b0, OFS_SETUP, 32'h0);
      chk(rd, RST_SETUP);
      chk(wo.phase_delay_en, 1);
      xfer(1'b0, OFS_CTRL, 32'h0);
      chk(rd, RST_CTRL);
      xfer(1'b0, OFS_TIMES1, 32'h0);
      chk(rd, RST_TIMES);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk(rd, {26'h0, ST_IDLE});
      xfer(1'b0, 8'h1C, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Manual factor 99 as advised for poor factor, then phase delay off, bad, on
      xfer(1'b1, OFS_SETUP, 32'h0099_0000);
      repeat (3) @(posedge pclk);
      chk(wo.phase_delay_en, 0);
      xfer(1'b1, OFS_SETUP, 32'h0099_0200);
      xfer(1'b0, OFS_SETUP, 32'h0);
      chk(rd, 32'h0099_0000);
      xfer(1'b1, OFS_SETUP, 32'h0099_0100);
      repeat (3) @(posedge pclk);
      chk(wo.phase_delay_en, 1);
      // Turns ratio below the floor and at the ceiling
      xfer(1'b1, OFS_CTRL, 32'h0000_0005);
      xfer(1'b0, OFS_CTRL, 32'h0);
      chk(rd, {24'h0, TR_MIN});
      xfer(1'b1, OFS_CTRL, 32'h0000_00FF);
      xfer(1'b0, OFS_CTRL, 32'h0);
      chk(rd, {24'h0, TR_MAX});
      // Cycle mode 05 is only accepted under initiation mode 05
      xfer(1'b1, OFS_CTRL, 32'h0005_000A);
      xfer(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_000A);
      xfer(1'b1, OFS_SETUP, 32'h0099_0105);
      xfer(1'b1, OFS_CTRL, 32'h0005_000A);
      xfer(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h0005_000A);
      // Every constant-current code, ratio 20 on a 100 A primary reading
      far.set_current(16'd100);
      for (int i = 0; i < 15; i++) begin
         xfer(1'b1, OFS_CTRL, {16'h0, cc_code[i], 8'd20});
         repeat (3) @(posedge pclk);
         chk(wo.range_sel, cc_rng[i]);
         chk(wo.compensate, cc_code[i] != 8'h00 && !cc_code[i][0]);
         chk(wo.monitor, cc_code[i] != 8'h00);
         // Only primary codes scale by the ratio; others pass the reading through
         xfer(1'b0, OFS_CURRENT, 32'h0);
         chk(rd, (cc_code[i][7:4] == 4'h1) ? 32'd2000 : 32'd100);
      end
      // Start with a pre-squeeze, then abort it from the estop
      xfer(1'b1, OFS_TIMES0, 32'h0505_0505);
      far.set_pilot(1'b1);
      repeat (6) @(posedge pclk);
      chk(wo.valve_on, 1);
      chk(wo.display_dim, 1);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk(rd, {26'h0, ST_PRESQZ});
      far.set_pilot(1'b0);
      far.estop_pulse(1'b0, 4);
      repeat (4) @(posedge pclk);
      chk(wo.valve_on, 0);
      chk(wo.retract, 0);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk(rd, {26'h0, ST_IDLE});
      // Zero pre-squeeze goes straight to SQUEEZE at full brightness
      xfer(1'b1, OFS_TIMES0, 32'h0505_0500);
      far.set_pilot(1'b1);
      repeat (6) @(posedge pclk);
      chk(wo.display_dim, 0);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk(rd, {26'h0, ST_SQUEEZE});
      far.set_pilot(1'b0);
      far.estop_pulse(1'b0, 4);
      repeat (4) @(posedge pclk);
      // Mode 04: inhibit opening cuts WELD, then blocking overlaps OFF with retraction
      xfer(1'b1, OFS_SETUP, 32'h0799_0104);
      xfer(1'b1, OFS_TIMES1, 32'h0000_0305);
      xfer(1'b1, OFS_TIMES0, 32'h0005_0000);
      far.set_pilot(1'b1);
      repeat (6) @(posedge pclk);
      chk(wo.weld_fire, 1);
      chk(wo.valve3, 0);
      far.set_inhibit(1'b1);
      repeat (6) @(posedge pclk);
      chk(wo.weld_fire, 0);
      chk(wo.retract, 1);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk(rd, {26'h0, ST_OFF});
      xfer(1'b0, OFS_PF_READ, 32'h0);
      chk(rd, 32'h0000_0055);
      far.set_pilot(1'b0);
      far.set_inhibit(1'b0);
      far.estop_pulse(1'b0, 4);
      repeat (4) @(posedge pclk);
      chk(wo.retract, 0);
      chk(wo.valve_on, 0);
      // Stepper reset mode: a closure after an open spell pulses the output
      xfer(1'b1, OFS_SETUP, 32'h0099_0106);
      chk(step_seen, 0);
      far.estop_pulse(1'b0, 6);
      repeat (8) @(posedge pclk);
      chk(step_seen, 1);
      end_of_test();
   end
endmodule
